// ==== common/tcu_pkg.sv ====
// Purpose: constants and types shared by the 8-bit timer/counter
// Assumes: one 25 MHz clock, registers reached through plain ports
// Notes: mode codes follow the three-bit waveform mode field
`default_nettype none
package tcu_pkg;
  localparam int unsigned CNT_W = 8;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] CNT_RESET = 8'h00;
  localparam logic [2:0] CS_NONE = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam int unsigned PSC_W = 10;
  localparam logic [9:0] PSC_8 = 10'h007;
  localparam logic [9:0] PSC_64 = 10'h03F;
  localparam logic [9:0] PSC_256 = 10'h0FF;
  localparam logic [9:0] PSC_1024 = 10'h3FF;
  // waveform modes
  localparam logic [2:0] WM_NORMAL = 3'h0;
  localparam logic [2:0] WM_PC_MAX = 3'h1;
  localparam logic [2:0] WM_CTC = 3'h2;
  localparam logic [2:0] WM_FAST_MAX = 3'h3;
  localparam logic [2:0] WM_PC_OCRA = 3'h5;
  localparam logic [2:0] WM_FAST_OCRA = 3'h7;
  // compare output actions
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;
  typedef enum logic [1:0] {
    TCU_DIR_UP = 2'b01,
    TCU_DIR_DOWN = 2'b10
  } tcu_dir_t;
endpackage : tcu_pkg
`default_nettype wire

// ==== tb/tcu_testbench.sv ====
// Purpose: self-checking bench for the 8-bit timer/counter
// Assumes: bench drives every port of tcu_timer directly, no partner model
// Notes: exact counts over several ticks use the external pin, one tick per pulse
`default_nettype none
`define CHK(got, exp) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("Error at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module testbench
  import tcu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, external_count_input, waveform_mode_bit2;
  logic counter_wr, compare_a_wr, compare_b_wr, flag_reg_wr, mask_reg_wr;
  logic force_compare_strobe_a, force_compare_strobe_b;
  logic compare_output_a, compare_output_b;
  logic [1:0] waveform_mode_bits10, compare_output_mode_a, compare_output_mode_b;
  logic [2:0] clock_source_select, flag_reg_wdata, irq_ack, mask_reg_wdata;
  logic [2:0] interrupt_flag_reg, interrupt_mask_reg, irq_req;
  logic [7:0] counter_wdata, compare_wdata, counter_value;
  logic [7:0] compare_value_a, compare_value_b;
  int fail_count, checks_done, cycles;

  tcu_timer DUT (.clk, .rst_n, .clock_source_select, .waveform_mode_bits10,
    .waveform_mode_bit2, .compare_output_mode_a, .compare_output_mode_b,
    .external_count_input, .counter_wr, .counter_wdata, .counter_value,
    .compare_a_wr, .compare_b_wr, .compare_wdata, .compare_value_a,
    .compare_value_b, .force_compare_strobe_a, .force_compare_strobe_b,
    .flag_reg_wr, .flag_reg_wdata, .irq_ack, .mask_reg_wr, .mask_reg_wdata,
    .interrupt_flag_reg, .interrupt_mask_reg, .irq_req, .compare_output_a,
    .compare_output_b);

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  // bounds a hang in any scenario
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      fail_count++;
      report_and_stop();
    end
  end

  task automatic done(input string name);
    $display("test %s finished, checks so far %0d", name, checks_done);
  endtask : done

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic set_mode(input logic [2:0] m, input logic [2:0] cs);
    @(posedge clk);
    waveform_mode_bit2 <= m[2];
    waveform_mode_bits10 <= m[1:0];
    clock_source_select <= cs;
  endtask : set_mode

  task automatic wr_cnt(input logic [7:0] d);
    @(posedge clk);
    counter_wr <= 1'b1;
    counter_wdata <= d;
    @(posedge clk);
    counter_wr <= 1'b0;
    #1;
  endtask : wr_cnt

  // one-cycle strobe: 0 cmp a, 1 cmp b, 2 flag, 3 mask, 4 ack, else force
  task automatic strobe(input int which, input logic [7:0] d);
    @(posedge clk);
    compare_wdata <= d;
    flag_reg_wdata <= d[2:0];
    mask_reg_wdata <= d[2:0];
    case (which)
      0: compare_a_wr <= 1'b1;
      1: compare_b_wr <= 1'b1;
      2: flag_reg_wr <= 1'b1;
      3: mask_reg_wr <= 1'b1;
      4: irq_ack <= d[2:0];
      default: {force_compare_strobe_a, force_compare_strobe_b} <= 2'b11;
    endcase
    @(posedge clk);
    {compare_a_wr, compare_b_wr, flag_reg_wr, mask_reg_wr} <= 4'h0;
    irq_ack <= 3'h0;
    {force_compare_strobe_a, force_compare_strobe_b} <= 2'b00;
    #1;
  endtask : strobe

  // one full pulse on the pin, with time for sync and edge detect
  task automatic ext_pulse();
    @(posedge clk);
    external_count_input <= 1'b1;
    repeat (5) @(posedge clk);
    external_count_input <= 1'b0;
    step(8);
  endtask : ext_pulse

  task automatic t_reset();
    `CHK(counter_value, 8'h00);
    `CHK({compare_value_a, compare_value_b}, 16'h0000);
    `CHK({interrupt_flag_reg, interrupt_mask_reg}, 6'h00);
    `CHK({compare_output_a, compare_output_b}, 2'h0);
    done("reset");
  endtask : t_reset

  task automatic t_stop();
    wr_cnt(8'h5A);
    `CHK(counter_value, 8'h5A);
    step(6);
    `CHK(counter_value, 8'h5A);
    done("stop");
  endtask : t_stop

  task automatic t_ext();
    set_mode(3'h0, 3'h7);
    strobe(1, 8'h0A);
    `CHK(compare_value_b, 8'h0A);
    wr_cnt(8'h08);
    strobe(2, 8'h07);
    strobe(3, 8'h04);
    `CHK(interrupt_mask_reg, 3'h4);
    ext_pulse();
    `CHK(counter_value, 8'h09);
    ext_pulse();
    `CHK(interrupt_flag_reg[2], 1'b0);
    ext_pulse();
    `CHK(interrupt_flag_reg[2], 1'b1);
    `CHK(irq_req, 3'h4);
    strobe(4, 8'h04);
    `CHK(interrupt_flag_reg[2], 1'b0);
    wr_cnt(8'h0A);
    ext_pulse();
    ext_pulse();
    `CHK(counter_value, 8'h0C);
    `CHK(interrupt_flag_reg[2], 1'b0);
    set_mode(3'h0, 3'h6);
    ext_pulse();
    `CHK(counter_value, 8'h0D);
    done("external");
  endtask : t_ext

  task automatic t_buf();
    set_mode(3'h3, 3'h7);
    strobe(1, 8'h2A);
    `CHK(compare_value_b, 8'h2A);
    wr_cnt(8'h28);
    strobe(2, 8'h07);
    repeat (3) ext_pulse();
    `CHK(counter_value, 8'h2B);
    `CHK(interrupt_flag_reg[2], 1'b0);
    set_mode(3'h0, 3'h0);
    done("buffer");
  endtask : t_buf

  task automatic t_run();
    wr_cnt(8'hFC);
    strobe(2, 8'h07);
    set_mode(3'h0, 3'h1);
    step(12);
    `CHK(interrupt_flag_reg[0], 1'b1);
    `CHK(counter_value < 8'h20, 1'b1);
    wr_cnt(8'h40);
    `CHK(counter_value, 8'h40);
    step(1);
    `CHK(counter_value, 8'h41);
    set_mode(3'h0, 3'h0);
    strobe(2, 8'h00);
    `CHK(interrupt_flag_reg[0], 1'b1);
    strobe(2, 8'h01);
    `CHK(interrupt_flag_reg[0], 1'b0);
    done("run");
  endtask : t_run

  task automatic t_ctc();
    logic [7:0] mx;
    int bad;
    mx = 8'h00;
    bad = 0;
    set_mode(3'h2, 3'h0);
    strobe(0, 8'h05);
    wr_cnt(8'h00);
    strobe(2, 8'h07);
    set_mode(3'h2, 3'h1);
    repeat (40)
    begin
      step(1);
      if (counter_value > 8'h05)
        bad++;
      if (counter_value > mx)
        mx = counter_value;
    end
    set_mode(3'h2, 3'h0);
    step(1);
    `CHK(bad, 0);
    `CHK(mx, 8'h05);
    `CHK(interrupt_flag_reg[1], 1'b1);
    done("ctc");
  endtask : t_ctc

  task automatic t_force();
    set_mode(3'h0, 3'h0);
    wr_cnt(8'h10);
    strobe(2, 8'h07);
    @(posedge clk);
    compare_output_mode_a <= 2'h1;
    compare_output_mode_b <= 2'h3;
    strobe(5, 8'h00);
    step(2);
    `CHK({compare_output_a, compare_output_b}, 2'b11);
    `CHK(interrupt_flag_reg, 3'h0);
    `CHK(counter_value, 8'h10);
    set_mode(3'h3, 3'h0);
    strobe(5, 8'h00);
    step(2);
    `CHK(compare_output_a, 1'b1);
    done("force");
  endtask : t_force

  task automatic t_presc();
    set_mode(3'h0, 3'h0);
    wr_cnt(8'h00);
    set_mode(3'h0, 3'h2);
    step(80);
    set_mode(3'h0, 3'h0);
    step(2);
    `CHK(counter_value >= 8'h09 && counter_value <= 8'h0B, 1'b1);
    done("prescale");
  endtask : t_presc

  task automatic t_pc();
    set_mode(3'h1, 3'h7);
    strobe(0, 8'h30);
    wr_cnt(8'hFE);
    repeat (3) ext_pulse();
    `CHK(counter_value, 8'hFD);
    set_mode(3'h0, 3'h0);
    step(1);
    `CHK(compare_value_a, 8'h30);
    done("phase");
  endtask : t_pc

  initial
  begin
    fail_count = 0;
    checks_done = 0;
    cycles = 0;
    rst_n = 1'b0;
    {external_count_input, waveform_mode_bit2, counter_wr} = 3'h0;
    {compare_a_wr, compare_b_wr, flag_reg_wr, mask_reg_wr} = 4'h0;
    {force_compare_strobe_a, force_compare_strobe_b} = 2'b00;
    {waveform_mode_bits10, compare_output_mode_a} = 4'h0;
    compare_output_mode_b = 2'h0;
    {clock_source_select, flag_reg_wdata, irq_ack, mask_reg_wdata} = 12'h000;
    {counter_wdata, compare_wdata} = 16'h0000;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    step(3);
    t_reset();
    t_stop();
    t_ext();
    t_buf();
    t_run();
    t_ctc();
    t_force();
    t_presc();
    t_pc();
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire

// ==== verilog/tcu_cmp_unit.sv ====
// Purpose: one output compare unit: compare register, buffer, flag, output
// Assumes: tick and update strobes come from the counter in the same clock
// Notes: the flag sets on the tick that moves the counter off a match
`default_nettype none
module tcu_cmp_unit
  import tcu_pkg::*;
#(
  parameter int unsigned W = 8
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic [W-1:0] cnt,
  input wire logic pwm_mode,
  input wire logic fast_mode,
  input wire logic buf_load,
  input wire logic cnt_wr,
  input wire logic cmp_wr,
  input wire logic [W-1:0] cmp_wdata,
  input wire logic [1:0] com,
  input wire logic force_cmp,
  input wire logic flag_clr_sw,
  input wire logic flag_clr_ack,
  input wire logic at_top,
  input wire logic at_bottom,
  input wire logic dir_up,
  output logic [W-1:0] cmp_rdata,
  output logic [W-1:0] cmp_active,
  output logic match,
  output logic flag,
  output logic oc
);
  import tcu_pkg::*;

  logic [W-1:0] ocr_r;
  logic [W-1:0] buf_r;
  logic block_r;
  logic oc_nxt;

  assign cmp_active = ocr_r;
  assign cmp_rdata = pwm_mode ? buf_r : ocr_r;
  assign match = (cnt == ocr_r) && !block_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      buf_r <= '0;
    else if (cmp_wr)
      buf_r <= cmp_wdata;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ocr_r <= '0;
    else if (!pwm_mode && cmp_wr)
      ocr_r <= cmp_wdata;
    else if (pwm_mode && buf_load)
      ocr_r <= buf_r;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      block_r <= 1'b0;
    else if (cnt_wr)
      block_r <= 1'b1;
    else if (tick)
      block_r <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      flag <= 1'b0;
    else if (tick && match)
      flag <= 1'b1;
    else if (flag_clr_sw || flag_clr_ack)
      flag <= 1'b0;
  end

  always_comb
  begin
    oc_nxt = oc;
    if (!pwm_mode)
    begin
      if ((tick && match) || force_cmp)
      begin
        case (com)
          COM_TOGGLE: oc_nxt = ~oc;
          COM_CLEAR: oc_nxt = 1'b0;
          COM_SET: oc_nxt = 1'b1;
          default: oc_nxt = oc;
        endcase
      end
    end
    else if (tick && com[1])
    begin
      if (fast_mode)
      begin
        if (match)
          oc_nxt = com[0];
        else if (at_bottom)
          oc_nxt = ~com[0];
      end
      else if (match)
        oc_nxt = dir_up ? com[0] : ~com[0];
      else if (at_top && ocr_r != cnt)
        oc_nxt = com[0];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      oc <= 1'b0;
    else
      oc <= oc_nxt;
  end
endmodule : tcu_cmp_unit
`default_nettype wire

// ==== verilog/tcu_timer.sv ====
// Purpose: 8-bit timer/counter with two compare units and three flags
// Assumes: clk 25 MHz, control bits as plain ports, strobes one cycle wide
// Notes: interrupt acknowledges clear flags; software clears by writing one
`default_nettype none
module tcu_timer
  import tcu_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] clock_source_select,
  input wire logic [1:0] waveform_mode_bits10,
  input wire logic waveform_mode_bit2,
  input wire logic [1:0] compare_output_mode_a,
  input wire logic [1:0] compare_output_mode_b,
  input wire logic external_count_input,
  input wire logic counter_wr,
  input wire logic [tcu_pkg::CNT_W-1:0] counter_wdata,
  output logic [tcu_pkg::CNT_W-1:0] counter_value,
  input wire logic compare_a_wr,
  input wire logic compare_b_wr,
  input wire logic [tcu_pkg::CNT_W-1:0] compare_wdata,
  output logic [tcu_pkg::CNT_W-1:0] compare_value_a,
  output logic [tcu_pkg::CNT_W-1:0] compare_value_b,
  input wire logic force_compare_strobe_a,
  input wire logic force_compare_strobe_b,
  input wire logic flag_reg_wr,
  input wire logic [2:0] flag_reg_wdata,
  input wire logic [2:0] irq_ack,
  input wire logic mask_reg_wr,
  input wire logic [2:0] mask_reg_wdata,
  output logic [2:0] interrupt_flag_reg,
  output logic [2:0] interrupt_mask_reg,
  output logic [2:0] irq_req,
  output logic compare_output_a,
  output logic compare_output_b
);
  import tcu_pkg::*;

  logic rst_s1_r;
  logic rst_s2_r;
  logic srst_n;
  logic ext_s1_r;
  logic ext_s2_r;
  logic ext_d_r;
  logic [PSC_W-1:0] psc_r;
  logic tick;
  logic [2:0] wm;
  logic pwm_mode;
  logic fast_mode;
  logic pc_mode;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] top;
  tcu_dir_t dir_r;
  logic at_bottom;
  logic at_max;
  logic at_top;
  logic buf_load;
  logic match_a;
  logic match_b;
  logic [CNT_W-1:0] ocra_act;
  logic ov_flag_r;
  logic ov_set;
  logic flag_a;
  logic flag_b;
  logic [2:0] mask_r;

  // reset release through two flops
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  assign srst_n = rst_s2_r;

  // external pin synchroniser
  always_ff @(posedge clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_d_r <= 1'b0;
    end
    else
    begin
      ext_s1_r <= external_count_input;
      ext_s2_r <= ext_s1_r;
      ext_d_r <= ext_s2_r;
    end
  end

  always_ff @(posedge clk or negedge srst_n)
  begin
    if (!srst_n)
      psc_r <= '0;
    else
      psc_r <= psc_r + 1'b1;
  end

  always_comb
  begin
    case (clock_source_select)
      CS_NONE: tick = 1'b0;
      CS_DIV1: tick = 1'b1;
      CS_DIV8: tick = (psc_r[2:0] == PSC_8[2:0]);
      CS_DIV64: tick = (psc_r[5:0] == PSC_64[5:0]);
      CS_DIV256: tick = (psc_r[7:0] == PSC_256[7:0]);
      CS_DIV1024: tick = (psc_r == PSC_1024);
      CS_EXT_FALL: tick = ext_d_r && !ext_s2_r;
      CS_EXT_RISE: tick = !ext_d_r && ext_s2_r;
      default: tick = 1'b0;
    endcase
  end

  assign wm = {waveform_mode_bit2, waveform_mode_bits10};
  assign fast_mode = (wm == WM_FAST_MAX) || (wm == WM_FAST_OCRA);
  assign pc_mode = (wm == WM_PC_MAX) || (wm == WM_PC_OCRA);
  assign pwm_mode = fast_mode || pc_mode;

  assign top = (wm == WM_CTC || wm == WM_PC_OCRA || wm == WM_FAST_OCRA) ? ocra_act : CNT_MAX;
  assign at_bottom = (cnt_r == CNT_BOTTOM);
  assign at_max = (cnt_r == CNT_MAX);
  assign at_top = (cnt_r == top);

  always_comb
  begin
    cnt_nxt = cnt_r;
    if (pc_mode)
    begin
      if (dir_r == TCU_DIR_UP)
        cnt_nxt = at_top ? cnt_r - 1'b1 : cnt_r + 1'b1;
      else
        cnt_nxt = at_bottom ? cnt_r + 1'b1 : cnt_r - 1'b1;
    end
    else if (wm != WM_NORMAL && at_top)
      cnt_nxt = CNT_BOTTOM;
    else
      cnt_nxt = cnt_r + 1'b1;
  end

  always_ff @(posedge clk or negedge srst_n)
  begin
    if (!srst_n)
      cnt_r <= CNT_RESET;
    else if (counter_wr)
      cnt_r <= counter_wdata;
    else if (tick)
      cnt_r <= cnt_nxt;
  end

  always_ff @(posedge clk or negedge srst_n)
  begin
    if (!srst_n)
      dir_r <= TCU_DIR_UP;
    else if (!pc_mode)
      dir_r <= TCU_DIR_UP;
    else if (tick && at_top)
      dir_r <= TCU_DIR_DOWN;
    else if (tick && at_bottom)
      dir_r <= TCU_DIR_UP;
  end

  assign buf_load = tick && (pc_mode ? at_top : at_bottom);

  assign ov_set = tick && !counter_wr && (pc_mode ? at_bottom : (at_max || (fast_mode && at_top)));

  always_ff @(posedge clk or negedge srst_n)
  begin
    if (!srst_n)
      ov_flag_r <= 1'b0;
    else if (ov_set)
      ov_flag_r <= 1'b1;
    else if ((flag_reg_wr && flag_reg_wdata[0]) || irq_ack[0])
      ov_flag_r <= 1'b0;
  end

  always_ff @(posedge clk or negedge srst_n)
  begin
    if (!srst_n)
      mask_r <= '0;
    else if (mask_reg_wr)
      mask_r <= mask_reg_wdata;
  end

  tcu_cmp_unit #(.W(CNT_W)) u_cmp_a (
    .clk(clk),
    .rst_n(srst_n),
    .tick(tick),
    .cnt(cnt_r),
    .pwm_mode(pwm_mode),
    .fast_mode(fast_mode),
    .buf_load(buf_load),
    .cnt_wr(counter_wr),
    .cmp_wr(compare_a_wr),
    .cmp_wdata(compare_wdata),
    .com(compare_output_mode_a),
    .force_cmp(force_compare_strobe_a),
    .flag_clr_sw(flag_reg_wr && flag_reg_wdata[1]),
    .flag_clr_ack(irq_ack[1]),
    .at_top(at_top),
    .at_bottom(at_bottom),
    .dir_up(dir_r == TCU_DIR_UP),
    .cmp_rdata(compare_value_a),
    .cmp_active(ocra_act),
    .match(match_a),
    .flag(flag_a),
    .oc(compare_output_a)
  );

  tcu_cmp_unit #(.W(CNT_W)) u_cmp_b (
    .clk(clk),
    .rst_n(srst_n),
    .tick(tick),
    .cnt(cnt_r),
    .pwm_mode(pwm_mode),
    .fast_mode(fast_mode),
    .buf_load(buf_load),
    .cnt_wr(counter_wr),
    .cmp_wr(compare_b_wr),
    .cmp_wdata(compare_wdata),
    .com(compare_output_mode_b),
    .force_cmp(force_compare_strobe_b),
    .flag_clr_sw(flag_reg_wr && flag_reg_wdata[2]),
    .flag_clr_ack(irq_ack[2]),
    .at_top(at_top),
    .at_bottom(at_bottom),
    .dir_up(dir_r == TCU_DIR_UP),
    .cmp_rdata(compare_value_b),
    .cmp_active(),
    .match(match_b),
    .flag(flag_b),
    .oc(compare_output_b)
  );

  assign counter_value = cnt_r;
  assign interrupt_flag_reg = {flag_b, flag_a, ov_flag_r};
  assign interrupt_mask_reg = mask_r;
  assign irq_req = interrupt_flag_reg & mask_r;

  property p_stop_hold;
    @(posedge clk) disable iff (!srst_n)
    (clock_source_select == CS_NONE && !counter_wr) |=> $stable(cnt_r);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("counter moved while stopped");

  property p_wr_wins;
    @(posedge clk) disable iff (!srst_n)
    counter_wr |=> cnt_r == $past(counter_wdata);
  endproperty
  a_wr_wins: assert property (p_wr_wins) else $error("counter write lost");

  property p_normal_wrap;
    @(posedge clk) disable iff (!srst_n)
    (wm == WM_NORMAL && tick && at_max && !counter_wr) |=> cnt_r == CNT_BOTTOM && ov_flag_r;
  endproperty
  a_normal_wrap: assert property (p_normal_wrap) else $error("normal wrap or overflow missing");

  property p_ctc_clear;
    @(posedge clk) disable iff (!srst_n)
    (wm == WM_CTC && tick && cnt_r == ocra_act && !counter_wr) |=> cnt_r == CNT_BOTTOM;
  endproperty
  a_ctc_clear: assert property (p_ctc_clear) else $error("ctc clear missing");

  property p_up_count;
    @(posedge clk) disable iff (!srst_n)
    (wm == WM_NORMAL && tick && !counter_wr) |=> cnt_r == $past(cnt_r) + 8'h01;
  endproperty
  a_up_count: assert property (p_up_count) else $error("count step wrong");

  property p_irq_mask;
    @(posedge clk) disable iff (!srst_n)
    (interrupt_flag_reg[0] && !mask_r[0]) |-> !irq_req[0];
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked request raised");

  property p_flag_clear;
    @(posedge clk) disable iff (!srst_n)
    (flag_reg_wr && flag_reg_wdata[1] && !tick) |=> !flag_a;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag a not cleared");

  property p_direct_cmp;
    @(posedge clk) disable iff (!srst_n)
    (!pwm_mode && compare_a_wr) |=> ocra_act == $past(compare_wdata);
  endproperty
  a_direct_cmp: assert property (p_direct_cmp) else $error("direct compare write lost");

  property p_flag_next_tick;
    @(posedge clk) disable iff (!srst_n)
    (tick && match_a) |=> flag_a;
  endproperty
  a_flag_next_tick: assert property (p_flag_next_tick) else $error("flag a missed its tick");

  property p_flag_not_early;
    @(posedge clk) disable iff (!srst_n)
    (!(tick && match_a) && !flag_a) |=> !flag_a;
  endproperty
  a_flag_not_early: assert property (p_flag_not_early) else $error("flag a set early");

  c_ovf: cover property (@(posedge clk) disable iff (!srst_n) $rose(ov_flag_r));
  c_flag_a: cover property (@(posedge clk) disable iff (!srst_n) $rose(flag_a));
  c_pwm_load: cover property (@(posedge clk) disable iff (!srst_n) pwm_mode && buf_load);
  c_toggle: cover property (@(posedge clk) disable iff (!srst_n) $changed(compare_output_a));
endmodule : tcu_timer
`default_nettype wire
